// >>> rtl/link_status_regs.sv
// Purpose: Link status word refresh, station bitmaps and network parameter registers.
// Assumes: Link engine inputs share CLK_SYS_I; only the version strap is a pin.
// Notes: Words not in the refresh tables are not stored and read as zero.
module link_status_regs (
	input wire logic CLK_SYS_I, // System clock, 40 MHz
	input wire logic NRST_I, // Synchronous reset, active low
	input wire logic [8:0] ADDR_I, // Register address
	input wire logic [15:0] WDATA_I, // Write data
	input wire logic WR_I, // Write strobe
	input wire logic RD_I, // Read strobe
	input wire link_status_pkg::sb_type LINK_SB_I, // Live link status bits
	input wire logic UPD_VALID_I, // Link engine word update
	input wire logic [7:0] UPD_NUM_I, // Word number updated
	input wire logic [15:0] UPD_DATA_I, // New word value
	input wire link_status_pkg::stn_type STN_I, // Station report
	input wire logic LINK_STARTUP_I, // High while the link starts up
	input wire logic FUNC_VER_A_I, // Pin strap: earliest function version
	output logic [15:0] RDATA_O, // Read data, cycle after the read strobe
	output logic IRQ_O, // Level interrupt
	output link_status_pkg::cfg_type CFG_O // Network parameter settings
);

	logic [15:0] shown_q [256];
	logic [15:0] shown_d [256];
	logic [15:0] pend_q [256];
	logic [15:0] pend_d [256];
	link_status_pkg::sb_type sb_prev_q;
	link_status_pkg::sb_type sb_prev_d;
	logic [63:0] ovl_acc_q;
	logic [63:0] ovl_acc_d;
	logic [63:0] mis_acc_q;
	logic [63:0] mis_acc_d;
	logic [63:0] line_q;
	logic [63:0] line_d;
	logic startup_q;
	logic startup_d;
	link_status_pkg::cfg_type cfg_q;
	link_status_pkg::cfg_type cfg_d;
	logic [link_status_pkg::IRQ_W-1:0] irq_stat_q;
	logic [link_status_pkg::IRQ_W-1:0] irq_stat_d;
	logic [link_status_pkg::IRQ_W-1:0] irq_en_q;
	logic [link_status_pkg::IRQ_W-1:0] irq_en_d;
	logic irq_q;
	logic irq_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic ver_meta_q;
	logic ver_a_q;
	logic [63:0] first_mask;
	logic [63:0] occ_mask;

	// Which words are kept and what, if anything, gates their refresh
	function automatic link_status_pkg::kind_type word_kind(input logic [7:0] num);
		link_status_pkg::kind_type k;
		k = '{stored: 1'b0, gated: 1'b0, bitmap: 1'b0, sb_idx: 3'h0};
		case (num) inside
			8'h60: k = '{1'b1, 1'b1, 1'b0, 3'(link_status_pkg::SB60_IDX)};
			8'h61: k = '{1'b1, 1'b1, 1'b0, 3'(link_status_pkg::SB61_IDX)};
			[8'h74:8'h77]: k = '{1'b1, 1'b1, 1'b0, 3'(link_status_pkg::SB74_IDX)};
			[8'h78:8'h7B]: k = '{1'b1, 1'b1, 1'b0, 3'(link_status_pkg::SB75_IDX)};
			[8'h80:8'h83]: k = '{1'b1, 1'b1, 1'b0, 3'(link_status_pkg::SB80_IDX)};
			8'h90: k = '{1'b1, 1'b1, 1'b0, 3'(link_status_pkg::SB90_IDX)};
			8'h41, 8'h45, 8'h62, [8'h67:8'h6A], [8'h6D:8'h72], [8'h88:8'h8B],
			8'hB8, 8'hB9: k.stored = 1'b1;
			[8'h98:8'h9F], [8'hB4:8'hB7]: begin
				k.stored = 1'b1;
				k.bitmap = 1'b1;
			end
			default: k.stored = 1'b0;
		endcase
		return k;
	endfunction : word_kind

	// Range check of a parameter write; mode and version steer the locks
	// Locks use the mode already held, so a mode write counts from the next access on
	function automatic logic param_ok(input logic [8:0] addr, input logic [15:0] data,
			input logic [1:0] mode, input logic ver_a);
		logic io_mode;
		logic ok;
		io_mode = (mode == link_status_pkg::MODE_REMOTE_IO);
		ok = 1'b0;
		case (addr)
			link_status_pkg::ADDR_START_IO: ok = (data <= link_status_pkg::START_IO_MAX);
			link_status_pkg::ADDR_OPER: ok = (data[15:2] == 14'h0000);
			link_status_pkg::ADDR_SCAN: ok = (data[15:1] == 15'h0000) && !(ver_a && io_mode);
			link_status_pkg::ADDR_TYPE_MODE: ok = (data[15:4] == 12'h000) && (data[3:2] != 2'h3);
			link_status_pkg::ADDR_CONNECT: ok = (data >= link_status_pkg::CONNECT_MIN) &&
					(data <= link_status_pkg::CONNECT_MAX);
			link_status_pkg::ADDR_RETRY: ok = !io_mode && (data >= link_status_pkg::RETRY_MIN) &&
					(data <= link_status_pkg::RETRY_MAX);
			link_status_pkg::ADDR_RECONN: ok = !io_mode && (data >= link_status_pkg::RECONN_MIN) &&
					(data <= link_status_pkg::RECONN_MAX);
			link_status_pkg::ADDR_STANDBY: ok = !io_mode &&
					(data <= link_status_pkg::STANDBY_MAX);
			link_status_pkg::ADDR_DELAY: ok = !io_mode &&
					(data <= link_status_pkg::DELAY_MAX);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : param_ok

	function automatic logic is_param(input logic [8:0] addr);
		return (addr >= link_status_pkg::ADDR_START_IO) && (addr <= link_status_pkg::ADDR_DELAY);
	endfunction : is_param

	station_mask u_first_mask (
		.first_i(STN_I.first),
		.occupied_i(STN_I.occupied),
		.first_only_i(1'b1),
		.mask_o(first_mask)
	);

	station_mask u_occ_mask (
		.first_i(STN_I.first),
		.occupied_i(STN_I.occupied),
		.first_only_i(1'b0),
		.mask_o(occ_mask)
	);

	// Version strap is a pin; two flops before anyone looks at it
	// A scan write within two cycles of a strap change is judged on the old version
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			ver_meta_q <= 1'b0;
			ver_a_q <= 1'b0;
		end else begin
			ver_meta_q <= FUNC_VER_A_I;
			ver_a_q <= ver_meta_q;
		end
	end

	// Station bitmaps
	always_comb begin
		startup_d = LINK_STARTUP_I;
		ovl_acc_d = ovl_acc_q;
		mis_acc_d = mis_acc_q;
		line_d = line_q;
		if (LINK_STARTUP_I && !startup_q) begin
			ovl_acc_d = 64'h0000000000000000;
			mis_acc_d = 64'h0000000000000000;
		end
		if (STN_I.valid) begin
			if (LINK_STARTUP_I) begin
				// Reports outside startup are not checked for these bitmaps
				if (STN_I.overlap) begin
					ovl_acc_d = ovl_acc_d | first_mask;
				end
				if (STN_I.mismatch) begin
					mis_acc_d = mis_acc_d | first_mask;
				end
			end
			line_d = STN_I.line_bad ? (line_q | occ_mask) : (line_q & ~occ_mask);
		end
	end

	// Link status words
	always_comb begin
		link_status_pkg::kind_type k;
		logic [7:0] num;
		int i;
		int j;
		k = '{stored: 1'b0, gated: 1'b0, bitmap: 1'b0, sb_idx: 3'h0};
		num = 8'h00;
		i = 0;
		j = 0;
		sb_prev_d = LINK_SB_I;
		shown_d = shown_q;
		pend_d = pend_q;
		if (UPD_VALID_I) begin
			k = word_kind(UPD_NUM_I);
			// Bitmap words belong to the station logic; engine writes to them are dropped
			if (k.stored && !k.bitmap) begin
				if (k.gated) begin
					pend_d[UPD_NUM_I] = UPD_DATA_I;
				end else begin
					shown_d[UPD_NUM_I] = UPD_DATA_I;
				end
			end
		end
		// Commit from pend_d so an update in the same cycle as the bit change is not missed
		for (i = 0; i < 256; i++) begin
			num = 8'(i);
			k = word_kind(num);
			if (k.gated && (LINK_SB_I[k.sb_idx] != sb_prev_q[k.sb_idx])) begin
				shown_d[i] = pend_d[i];
			end
		end
		for (j = 0; j < 4; j++) begin
			shown_d[int'(link_status_pkg::LINETEST_BASE) + j] = line_d[16*j +: 16];
			if (startup_q && !LINK_STARTUP_I) begin
				shown_d[int'(link_status_pkg::OVERLAP_BASE) + j] = ovl_acc_d[16*j +: 16];
				shown_d[int'(link_status_pkg::CONSIST_BASE) + j] = mis_acc_d[16*j +: 16];
			end
		end
	end

	// Parameters, interrupts and read port
	always_comb begin
		logic wr_ok;
		logic [link_status_pkg::IRQ_W-1:0] ev;
		logic [link_status_pkg::IRQ_W-1:0] clr;
		link_status_pkg::kind_type rk;
		wr_ok = param_ok(ADDR_I, WDATA_I, cfg_q.mode, ver_a_q);
		ev = '0;
		clr = '0;
		rk = word_kind(ADDR_I[7:0]);
		cfg_d = cfg_q;
		irq_en_d = irq_en_q;
		if (WR_I && is_param(ADDR_I)) begin
			if (wr_ok) begin
				case (ADDR_I)
					link_status_pkg::ADDR_START_IO: cfg_d.start_io = WDATA_I;
					link_status_pkg::ADDR_OPER: begin
						cfg_d.hold_input = WDATA_I[link_status_pkg::OPER_HOLD_BIT];
						cfg_d.plc_continue = WDATA_I[link_status_pkg::OPER_CONT_BIT];
					end
					link_status_pkg::ADDR_SCAN: cfg_d.scan_sync = WDATA_I[0];
					link_status_pkg::ADDR_TYPE_MODE: begin
						cfg_d.stn_kind = WDATA_I[link_status_pkg::TYPE_LSB +: 2];
						cfg_d.mode = WDATA_I[link_status_pkg::MODE_LSB +: 2];
					end
					link_status_pkg::ADDR_CONNECT: cfg_d.connect = WDATA_I[6:0];
					link_status_pkg::ADDR_RETRY: cfg_d.retry = WDATA_I[2:0];
					link_status_pkg::ADDR_RECONN: cfg_d.reconn = WDATA_I[3:0];
					link_status_pkg::ADDR_STANDBY: cfg_d.standby = WDATA_I[6:0];
					link_status_pkg::ADDR_DELAY: cfg_d.delay = WDATA_I[6:0];
					default: cfg_d = cfg_q;
				endcase
			end else begin
				ev[link_status_pkg::IRQ_REJECT_BIT] = 1'b1;
			end
		end
		if (WR_I && (ADDR_I == link_status_pkg::ADDR_IRQ_ENABLE)) begin
			irq_en_d = WDATA_I[link_status_pkg::IRQ_W-1:0];
		end
		if (WR_I && (ADDR_I == link_status_pkg::ADDR_IRQ_CLEAR)) begin
			clr = WDATA_I[link_status_pkg::IRQ_W-1:0];
		end
		ev[link_status_pkg::IRQ_REFRESH_BIT] = |(LINK_SB_I ^ sb_prev_q);
		ev[link_status_pkg::IRQ_STARTUP_BIT] = startup_q && !LINK_STARTUP_I;
		ev[link_status_pkg::IRQ_LINETEST_BIT] = STN_I.valid && STN_I.line_bad;
		// A new event beats a clear landing in the same cycle
		irq_stat_d = (irq_stat_q & ~clr) | ev;
		irq_d = |(irq_stat_d & irq_en_d);
		rdata_d = 16'h0000;
		if (RD_I) begin
			if (ADDR_I <= link_status_pkg::ADDR_WORD_LAST) begin
				rdata_d = rk.stored ? shown_q[ADDR_I[7:0]] : 16'h0000;
			end else begin
				case (ADDR_I)
					link_status_pkg::ADDR_START_IO: rdata_d = cfg_q.start_io;
					link_status_pkg::ADDR_OPER: rdata_d = {14'h0000, cfg_q.plc_continue, cfg_q.hold_input};
					link_status_pkg::ADDR_SCAN: rdata_d = {15'h0000, cfg_q.scan_sync};
					link_status_pkg::ADDR_TYPE_MODE: rdata_d = {12'h000, cfg_q.mode, cfg_q.stn_kind};
					link_status_pkg::ADDR_CONNECT: rdata_d = {9'h000, cfg_q.connect};
					link_status_pkg::ADDR_RETRY: rdata_d = {13'h0000, cfg_q.retry};
					link_status_pkg::ADDR_RECONN: rdata_d = {12'h000, cfg_q.reconn};
					link_status_pkg::ADDR_STANDBY: rdata_d = {9'h000, cfg_q.standby};
					link_status_pkg::ADDR_DELAY: rdata_d = {9'h000, cfg_q.delay};
					link_status_pkg::ADDR_IRQ_STATUS: rdata_d = {12'h000, irq_stat_q};
					link_status_pkg::ADDR_IRQ_ENABLE: rdata_d = {12'h000, irq_en_q};
					link_status_pkg::ADDR_LINK_BITS: rdata_d = {10'h000, sb_prev_q};
					default: rdata_d = 16'h0000;
				endcase
			end
		end
	end

	// Word store; pending copies clear too so a stale value never surfaces
	// Link bits are taken as low in reset; one high at release counts as a change
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			for (int i = 0; i < 256; i++) begin
				shown_q[i] <= 16'h0000;
				pend_q[i] <= 16'h0000;
			end
			sb_prev_q <= '0;
		end else begin
			shown_q <= shown_d;
			pend_q <= pend_d;
			sb_prev_q <= sb_prev_d;
		end
	end

	// Station bitmap state
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			ovl_acc_q <= 64'h0000000000000000;
			mis_acc_q <= 64'h0000000000000000;
			line_q <= 64'h0000000000000000;
			startup_q <= 1'b0;
		end else begin
			ovl_acc_q <= ovl_acc_d;
			mis_acc_q <= mis_acc_d;
			line_q <= line_d;
			startup_q <= startup_d;
		end
	end

	// Parameter, interrupt and read port state
	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			cfg_q.start_io <= 16'h0000;
			cfg_q.hold_input <= 1'b0;
			cfg_q.plc_continue <= 1'b0;
			cfg_q.scan_sync <= 1'b0;
			cfg_q.stn_kind <= link_status_pkg::TYPE_MASTER;
			cfg_q.mode <= link_status_pkg::MODE_REMOTE_NET;
			cfg_q.connect <= link_status_pkg::CONNECT_DEF;
			cfg_q.retry <= link_status_pkg::RETRY_DEF;
			cfg_q.reconn <= link_status_pkg::RECONN_DEF;
			cfg_q.standby <= link_status_pkg::STANDBY_BLANK;
			cfg_q.delay <= link_status_pkg::DELAY_DEF;
			irq_stat_q <= '0;
			irq_en_q <= '0;
			irq_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			cfg_q <= cfg_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign RDATA_O = rdata_q;
	assign IRQ_O = irq_q;
	assign CFG_O = cfg_q;

endmodule : link_status_regs

// >>> rtl/link_status_pkg.sv
// Purpose: Shared constants and carrier types of the link status register bank.
// Assumes: One 40 MHz clock; link engine signals arrive on that clock.
// Notes: Word numbers double as register indexes in the lower half of the map.
package link_status_pkg;

	// Register map, word addressed (9-bit address)
	localparam logic [8:0] ADDR_WORD_LAST = 9'h0FF;
	localparam logic [8:0] ADDR_START_IO = 9'h100;
	localparam logic [8:0] ADDR_OPER = 9'h101;
	localparam logic [8:0] ADDR_SCAN = 9'h102;
	localparam logic [8:0] ADDR_TYPE_MODE = 9'h103;
	localparam logic [8:0] ADDR_CONNECT = 9'h104;
	localparam logic [8:0] ADDR_RETRY = 9'h105;
	localparam logic [8:0] ADDR_RECONN = 9'h106;
	localparam logic [8:0] ADDR_STANDBY = 9'h107;
	localparam logic [8:0] ADDR_DELAY = 9'h108;
	localparam logic [8:0] ADDR_IRQ_STATUS = 9'h110;
	localparam logic [8:0] ADDR_IRQ_ENABLE = 9'h111;
	localparam logic [8:0] ADDR_IRQ_CLEAR = 9'h112;
	localparam logic [8:0] ADDR_LINK_BITS = 9'h113;

	// Field positions
	localparam int OPER_HOLD_BIT = 0;
	localparam int OPER_CONT_BIT = 1;
	localparam int TYPE_LSB = 0;
	localparam int MODE_LSB = 2;
	localparam int IRQ_REFRESH_BIT = 0;
	localparam int IRQ_STARTUP_BIT = 1;
	localparam int IRQ_REJECT_BIT = 2;
	localparam int IRQ_LINETEST_BIT = 3;
	localparam int IRQ_W = 4;

	// Mode and station type codes
	localparam logic [1:0] MODE_REMOTE_NET = 2'h0;
	localparam logic [1:0] MODE_REMOTE_IO = 2'h1;
	localparam logic [1:0] MODE_OFFLINE = 2'h2;
	localparam logic [1:0] TYPE_MASTER = 2'h0;

	// Parameter ranges and defaults
	localparam logic [15:0] START_IO_MAX = 16'h0FE0;
	localparam logic [15:0] CONNECT_MIN = 16'h0001;
	localparam logic [15:0] CONNECT_MAX = 16'h0040;
	localparam logic [15:0] RETRY_MIN = 16'h0001;
	localparam logic [15:0] RETRY_MAX = 16'h0007;
	localparam logic [15:0] RECONN_MIN = 16'h0001;
	localparam logic [15:0] RECONN_MAX = 16'h000A;
	localparam logic [15:0] STANDBY_MAX = 16'h0040;
	localparam logic [15:0] DELAY_MAX = 16'h0064;
	localparam logic [6:0] CONNECT_DEF = 7'h40;
	localparam logic [2:0] RETRY_DEF = 3'h3;
	localparam logic [3:0] RECONN_DEF = 4'h1;
	localparam logic [6:0] STANDBY_BLANK = 7'h00;
	localparam logic [6:0] DELAY_DEF = 7'h00;

	// Link status bits that gate word refresh, by index in sb_type
	localparam int SB60_IDX = 0;
	localparam int SB61_IDX = 1;
	localparam int SB74_IDX = 2;
	localparam int SB75_IDX = 3;
	localparam int SB80_IDX = 4;
	localparam int SB90_IDX = 5;
	localparam int SB_W = 6;

	// Station bitmap words
	localparam logic [7:0] OVERLAP_BASE = 8'h98;
	localparam logic [7:0] CONSIST_BASE = 8'h9C;
	localparam logic [7:0] LINETEST_BASE = 8'hB4;
	localparam int STATIONS = 64;

	typedef logic [SB_W-1:0] sb_type;

	typedef struct packed {
		logic valid;
		logic [6:0] first;
		logic [2:0] occupied;
		logic overlap;
		logic mismatch;
		logic line_bad;
	} stn_type;

	typedef struct packed {
		logic [15:0] start_io;
		logic hold_input;
		logic plc_continue;
		logic scan_sync;
		logic [1:0] stn_kind;
		logic [1:0] mode;
		logic [6:0] connect;
		logic [2:0] retry;
		logic [3:0] reconn;
		logic [6:0] standby;
		logic [6:0] delay;
	} cfg_type;

	typedef struct packed {
		logic stored;
		logic gated;
		logic bitmap;
		logic [2:0] sb_idx;
	} kind_type;

endpackage : link_status_pkg

// >>> rtl/station_mask.sv
// Purpose: Builds a 64-station bitmap for one station report.
// Assumes: Station numbers run 1 to 64; occupied count 1 to 4.
// Notes: Bits past station 64 are dropped rather than wrapped.
module station_mask (
	input wire logic [6:0] first_i, // First station number
	input wire logic [2:0] occupied_i, // Stations occupied
	input wire logic first_only_i, // Mark only the first station
	output logic [63:0] mask_o // One bit per station, bit 0 is station 1
);

	always_comb begin
		int n;
		int span;
		n = 0;
		mask_o = 64'h0000000000000000;
		span = first_only_i ? 1 : int'(occupied_i);
		for (n = 0; n < 64; n++) begin
			if ((n + 1 >= int'(first_i)) && (n + 1 < int'(first_i) + span) && (first_i != 7'h00)) begin
				mask_o[n] = 1'b1;
			end
		end
	end

endmodule : station_mask

// >>> dv/link_status_chk.sv
// Purpose: Port assertions for the link status register bank.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Word refresh and bitmaps need register reads, so the bench judges them.
module link_status_chk (
	input wire logic CLK_SYS_I, // System clock
	input wire logic NRST_I, // Reset, active low
	input wire logic [8:0] ADDR_I, // Register address
	input wire logic [15:0] WDATA_I, // Write data
	input wire logic WR_I, // Write strobe
	input wire link_status_pkg::cfg_type CFG_O // Settings
);
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!NRST_I);
	sequence s_wr_retry;
		WR_I && ADDR_I == link_status_pkg::ADDR_RETRY;
	endsequence
	sequence s_bad_retry;
		s_wr_retry ##0 (WDATA_I < link_status_pkg::RETRY_MIN || WDATA_I > link_status_pkg::RETRY_MAX);
	endsequence
	a_start_range: assert property (CFG_O.start_io <= link_status_pkg::START_IO_MAX)
		else $error("start io number out of range");
	a_count_ranges: assert property (CFG_O.connect != 7'h00 && CFG_O.connect <= 7'h40
		&& CFG_O.retry != 3'h0 && CFG_O.reconn != 4'h0 && CFG_O.reconn <= 4'hA)
		else $error("station, retry or reconnection count out of range");
	a_standby_range: assert property (CFG_O.standby <= 7'h40)
		else $error("standby master number out of range");
	a_delay_range: assert property (CFG_O.delay <= 7'h64)
		else $error("delay setting out of range");
	a_reset_defaults: assert property ($rose(NRST_I) |-> CFG_O.connect == 7'h40
		&& CFG_O.retry == 3'h3 && CFG_O.reconn == 4'h1 && CFG_O.standby == 7'h00
		&& CFG_O.delay == 7'h00 && !CFG_O.hold_input && !CFG_O.scan_sync)
		else $error("settings not at defaults after reset");
	a_bad_ignored: assert property (s_bad_retry |=> $stable(CFG_O.retry))
		else $error("illegal retry count taken");
	a_remote_lock: assert property (s_wr_retry ##0
		CFG_O.mode == link_status_pkg::MODE_REMOTE_IO |=> $stable(CFG_O.retry))
		else $error("retry count changed in remote io mode");
	a_retry_taken: assert property (s_wr_retry ##0 (WDATA_I >= link_status_pkg::RETRY_MIN
		&& WDATA_I <= link_status_pkg::RETRY_MAX
		&& CFG_O.mode != link_status_pkg::MODE_REMOTE_IO)
		|=> {13'h0000, CFG_O.retry} == $past(WDATA_I))
		else $error("legal retry count not taken");
endmodule : link_status_chk

bind link_status_regs link_status_chk chk (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .CFG_O(CFG_O));

// >>> dv/tb.sv
// Purpose: Self-checking bench for the link status register bank.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes: Tasks leave one idle cycle between accesses, trading speed for simplicity.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [8:0] addr = 9'h000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	link_status_pkg::sb_type sb = '0;
	logic upd = 1'b0;
	logic [7:0] unum = 8'h00;
	logic [15:0] udata = 16'h0000;
	link_status_pkg::stn_type stn = '0;
	logic startup = 1'b0;
	logic ver_a = 1'b0;
	logic [15:0] rdata;
	logic irq;
	link_status_pkg::cfg_type cfg;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	localparam logic [8:0] PA [9] = '{9'h100, 9'h101, 9'h102, 9'h103, 9'h104, 9'h105,
		9'h106, 9'h107, 9'h108};
	localparam logic [15:0] PD [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0040,
		16'h0003, 16'h0001, 16'h0000, 16'h0000};
	localparam logic [8:0] RA [6] = '{9'h100, 9'h104, 9'h105, 9'h106, 9'h107, 9'h108};
	localparam logic [15:0] RL [6] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0000,
		16'h0000};
	localparam logic [15:0] RH [6] = '{16'h0FE0, 16'h0040, 16'h0007, 16'h000A, 16'h0040,
		16'h0064};
	localparam logic [7:0] GW [6] = '{8'h60, 8'h61, 8'h74, 8'h7B, 8'h80, 8'h90};
	localparam logic [7:0] FW [5] = '{8'h41, 8'h45, 8'h72, 8'h88, 8'hB9};

	link_status_regs dut (.CLK_SYS_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .LINK_SB_I(sb), .UPD_VALID_I(upd), .UPD_NUM_I(unum),
		.UPD_DATA_I(udata), .STN_I(stn), .LINK_STARTUP_I(startup), .FUNC_VER_A_I(ver_a),
		.RDATA_O(rdata), .IRQ_O(irq), .CFG_O(cfg));

	always #12.5 clk = ~clk;

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	// A hang counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [8:0] a, input logic [15:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask : rd_reg

	task automatic put_word(input logic [7:0] n, input logic [15:0] d);
		@(posedge clk);
		upd <= 1'b1;
		unum <= n;
		udata <= d;
		@(posedge clk);
		upd <= 1'b0;
	endtask : put_word

	task automatic flip(input int b);
		@(posedge clk);
		sb[b] <= ~sb[b];
	endtask : flip

	// Flags are overlap, mismatch, line fault
	task automatic put_stn(input logic [6:0] f, input logic [2:0] o, input logic [2:0] k);
		@(posedge clk);
		stn <= {1'b1, f, o, k};
		@(posedge clk);
		stn.valid <= 1'b0;
	endtask : put_stn

	task automatic irq_is(input logic v);
		check({15'h0000, irq}, {15'h0000, v});
	endtask : irq_is

	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rd_reg(PA[i], PD[i]);
		end
		wr_reg(9'h111, 16'h0004);
		for (int i = 0; i < 6; i++) begin
			wr_reg(RA[i], RH[i]);
			rd_reg(RA[i], RH[i]);
			wr_reg(RA[i], RH[i] + 16'h0001);
			rd_reg(RA[i], RH[i]);
			irq_is(1'b1);
			wr_reg(9'h112, 16'h0004);
			wr_reg(RA[i], RL[i]);
			rd_reg(RA[i], RL[i]);
			irq_is(1'b0);
			if (RL[i] != 16'h0000) begin
				wr_reg(RA[i], 16'h0000);
				rd_reg(RA[i], RL[i]);
			end
		end
		wr_reg(9'h111, 16'h0000);
		wr_reg(9'h101, 16'h0001);
		wr_reg(9'h101, 16'h0004);
		rd_reg(9'h101, 16'h0001);
		rd_reg(9'h110, 16'h0004);
		irq_is(1'b0);
		wr_reg(9'h103, 16'h0004);
		rd_reg(9'h103, 16'h0004);
		for (int i = 2; i < 6; i++) begin
			wr_reg(RA[i], RH[i]);
			rd_reg(RA[i], RL[i]);
		end
		@(posedge clk);
		ver_a <= 1'b1;
		repeat (4) @(posedge clk);
		wr_reg(9'h102, 16'h0001);
		rd_reg(9'h102, 16'h0000);
		@(posedge clk);
		ver_a <= 1'b0;
		repeat (4) @(posedge clk);
		wr_reg(9'h102, 16'h0001);
		rd_reg(9'h102, 16'h0001);
		wr_reg(9'h103, 16'h0000);
		wr_reg(9'h105, 16'h0005);
		rd_reg(9'h105, 16'h0005);
		@(posedge clk);
		#1;
		check(rdata, 16'h0000);
		check({13'h0000, cfg.retry}, 16'h0005);
		wr_reg(9'h103, 16'h000C);
		rd_reg(9'h103, 16'h0000);
		wr_reg(9'h101, 16'h0003);
		rd_reg(9'h101, 16'h0003);
		check({15'h0000, cfg.hold_input}, 16'h0001);
		wr_reg(9'h112, 16'h000F);
		for (int i = 0; i < 6; i++) begin
			put_word(GW[i], {8'hA5, GW[i]});
			rd_reg({1'b0, GW[i]}, 16'h0000);
			flip(i);
			rd_reg({1'b0, GW[i]}, {8'hA5, GW[i]});
		end
		put_word(8'h78, 16'h1111);
		flip(2);
		rd_reg(9'h078, 16'h0000);
		flip(3);
		rd_reg(9'h078, 16'h1111);
		rd_reg(9'h110, 16'h0001);
		wr_reg(9'h111, 16'h0001);
		rd_reg(9'h113, 16'h0033);
		irq_is(1'b1);
		wr_reg(9'h111, 16'h000A);
		for (int i = 0; i < 5; i++) begin
			put_word(FW[i], {8'h5A, FW[i]});
			rd_reg({1'b0, FW[i]}, {8'h5A, FW[i]});
		end
		wr_reg(9'h112, 16'h000F);
		@(posedge clk);
		startup <= 1'b1;
		put_stn(7'd5, 3'd3, 3'b100);
		put_stn(7'd20, 3'd2, 3'b010);
		rd_reg(9'h098, 16'h0000);
		@(posedge clk);
		startup <= 1'b0;
		repeat (2) @(posedge clk);
		rd_reg(9'h098, 16'h0010);
		rd_reg(9'h09D, 16'h0008);
		rd_reg(9'h110, 16'h0002);
		irq_is(1'b1);
		put_stn(7'd16, 3'd3, 3'b001);
		rd_reg(9'h0B4, 16'h8000);
		rd_reg(9'h0B5, 16'h0003);
		put_stn(7'd16, 3'd3, 3'b000);
		rd_reg(9'h0B5, 16'h0000);
		test_done();
	end
endmodule : tb
